// ---- btsf_flags.sv ----
// Purpose: Internal flag logic of a single-channel bus transceiver
// Assumes: Comparator and pin inputs may be asynchronous; sync reset
// Notes:   Registers on classic Wishbone, one-cycle ack
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "btsf_consts.svh"
module btsf_flags #(
   parameter int TX_ACTIVE_LIMIT = `BTSF_TX_LIMIT_NS / `BTSF_CLK_NS   // Enable time limit
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        tx_enable_n_i,
   input  wire logic        txd_i,
   input  wire logic        bus_rx_i,
   input  wire logic        wake_pin_i,
   input  wire logic        remote_wake_i,
   input  wire logic        temp_warn_i,
   input  wire logic        temp_shutdown_i,
   input  wire logic        bat_low_i,
   input  wire logic        core_low_i,
   input  wire logic        io_low_i,
   output logic             tx_on_o,
   output logic             error_out_n_o,
   output logic      [2:0]  mode_o
);
   // ************************************************************
   // Input synchronisers
   // ************************************************************
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] raw;      // Raw asynchronous inputs
   logic [NSYNC-1:0] meta_r;   // First stage, read only by second stage
   logic [NSYNC-1:0] sync_r;   // Second stage, safe to use
   localparam logic [NSYNC-1:0] SYNC_RST = `BTSF_SYNC_RST;   // Pin idle levels
   assign raw = {io_low_i, core_low_i, bat_low_i, temp_shutdown_i, temp_warn_i,
                 remote_wake_i, wake_pin_i, bus_rx_i, txd_i, tx_enable_n_i};

   // Two flops per input
   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               meta_r[i] <= SYNC_RST[i];   // Idle level, no false edge after reset
               sync_r[i] <= SYNC_RST[i];
            end else begin
               meta_r[i] <= raw[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate
   logic tx_enable_n_n_s, txd_s, rx_s, wakepin_s, rwake_s, twarn_s, tsd_s;
   logic [2:0] low_s;          // Supply lows: io, core, bat
   assign {low_s, tsd_s, twarn_s, rwake_s, wakepin_s, rx_s, txd_s, tx_enable_n_n_s} = sync_r;
   // ************************************************************
   // Supply filters
   // ************************************************************
   localparam logic [`BTSF_CNT_W-1:0] DET_C = `BTSF_CNT_W'(`BTSF_UV_DET_NS / `BTSF_CLK_NS);
   localparam logic [`BTSF_CNT_W-1:0] REC_C = `BTSF_CNT_W'(`BTSF_UV_REC_NS / `BTSF_CLK_NS);
   btsf_uv_if uv_if [3] ();   // 0 battery, 1 core, 2 io
   logic [2:0] uv;            // Flags: io, core, bat
   logic       wake_set;      // Wake flag set this cycle

   generate
      for (genvar s = 0; s < 3; s++) begin : g_uv
         assign uv_if[s].low = low_s[s];
         assign uv_if[s].clr = wake_set;
         assign uv[s]        = uv_if[s].flag;
         btsf_uv_filter #(.DET_CYC(DET_C), .REC_CYC(REC_C)) u_filt (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .uv        (uv_if[s])
         );
      end
   endgenerate
   logic [2:0] uv_q_r;    // Previous flags for edge detect
   logic       uv_rise;   // Any flag newly set
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         uv_q_r <= 3'h0;
      end else begin
         uv_q_r <= uv;
      end
   end
   assign uv_rise = |(uv & ~uv_q_r);
   // ************************************************************
   // Mode control
   // ************************************************************
   btsf_pkg::btsf_mode_t mode_r;        // Effective mode
   btsf_pkg::btsf_mode_t mode_prev_r;   // Mode one cycle ago
   logic lp, np, normal, lp_entry, normal_entry;
   logic wb_req, wb_wr, st_read;
   logic ack_r;

   assign normal       = (mode_r == btsf_pkg::BTSF_NORMAL);
   assign np           = normal || (mode_r == btsf_pkg::BTSF_RX_ONLY);
   assign lp           = !np;
   assign lp_entry     = lp && ((mode_prev_r == btsf_pkg::BTSF_NORMAL) ||
                                (mode_prev_r == btsf_pkg::BTSF_RX_ONLY));
   assign normal_entry = normal && (mode_prev_r != btsf_pkg::BTSF_NORMAL);

   // Wake beats supply overrides, as it clears the supply flags; both beat the host
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_r <= btsf_pkg::btsf_mode_t'(`BTSF_MODE_RST);
      end else if (wake_set) begin
         mode_r <= btsf_pkg::BTSF_STANDBY;
      end else if (uv[0] || uv[2]) begin
         mode_r <= btsf_pkg::BTSF_SLEEP;
      end else if (uv[1] && (mode_r != btsf_pkg::BTSF_SLEEP)) begin
         mode_r <= btsf_pkg::BTSF_STANDBY;
      end else if (wb_wr && (wb_adr_i == `BTSF_ADR_CTRL) && wb_sel_i[0] && !uv[1] &&
                   (wb_dat_i[2:0] <= 3'h4)) begin
         mode_r <= btsf_pkg::btsf_mode_t'(wb_dat_i[2:0]);
      end
   end

   // History of the mode for entry detection
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_prev_r <= btsf_pkg::btsf_mode_t'(`BTSF_MODE_RST);
      end else begin
         mode_prev_r <= mode_r;
      end
   end
   // ************************************************************
   // Wake flags
   // ************************************************************
   logic local_r, remote_r, wake_r, pwron_r;
   logic local_set, remote_set;
   assign local_set  = lp && !wakepin_s;
   assign remote_set = lp && rwake_s;
   assign wake_set   = (local_set && !local_r) || (remote_set && !remote_r);

   // Local and remote sources; a set beats the entry clear
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         local_r  <= 1'b0;
         remote_r <= 1'b0;
      end else begin
         if (local_set) begin
            local_r <= 1'b1;
         end else if (lp_entry) begin
            local_r <= 1'b0;
         end
         if (remote_set) begin
            remote_r <= 1'b1;
         end else if (lp_entry) begin
            remote_r <= 1'b0;
         end
      end
   end

   // Combined wake flag
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wake_r <= 1'b0;
      end else if (wake_set) begin
         wake_r <= 1'b1;
      end else if (normal_entry || lp_entry || uv_rise) begin
         wake_r <= 1'b0;
      end
   end

   // Power-on flag starts set when the logic comes out of reset
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pwron_r <= 1'b1;
      end else if (normal_entry) begin
         pwron_r <= 1'b0;
      end
   end

   // ************************************************************
   // Thermal flags
   // ************************************************************
   logic twarn_r, tshut_r, tx_enable_n_q_r, tx_enable_n_fall;
   assign tx_enable_n_fall = tx_enable_n_q_r && !tx_enable_n_n_s;

   // Warning: set or clear only with healthy battery
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         twarn_r <= 1'b0;
      end else if (!uv[0]) begin
         if (np && twarn_s) begin
            twarn_r <= 1'b1;
         end else if ((np && !twarn_s) || (lp && st_read)) begin
            twarn_r <= 1'b0;
         end
      end
   end

   // Shutdown: latched until cool and enable falls
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         tshut_r <= 1'b0;
      end else if (np && tsd_s && !uv[0]) begin
         tshut_r <= 1'b1;
      end else if (np && !tsd_s && tx_enable_n_fall && !uv[0]) begin
         tshut_r <= 1'b0;
      end
   end

   // ************************************************************
   // Transmit timeout
   // ************************************************************
   logic [`BTSF_CNT_W-1:0] tx_cnt_r;   // Cycles with enable low in Normal
   logic                   tmo_r;

   // Count enable-low time; saturate at the limit
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || tx_enable_n_n_s || !normal) begin
         tx_cnt_r <= '0;
      end else if (tx_cnt_r != `BTSF_CNT_W'(TX_ACTIVE_LIMIT)) begin
         tx_cnt_r <= tx_cnt_r + 16'h0001;
      end
   end

   // Timeout flag
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || tx_enable_n_n_s || !normal) begin
         tmo_r <= 1'b0;
      end else if (tx_cnt_r == `BTSF_CNT_W'(TX_ACTIVE_LIMIT)) begin
         tmo_r <= 1'b1;
      end
   end

   // Driver is blocked by shutdown and timeout
   assign tx_on_o = normal && !tx_enable_n_n_s && !tshut_r && !tmo_r;

   // ************************************************************
   // Bus error
   // ************************************************************
   logic txd_q_r, smp_r, buserr_r;

   // Edge history of transmit data and enable
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         txd_q_r  <= 1'b0;
         tx_enable_n_q_r <= 1'b1;
         smp_r    <= 1'b0;
      end else begin
         txd_q_r  <= txd_s;
         tx_enable_n_q_r <= tx_enable_n_n_s;
         smp_r    <= (txd_s != txd_q_r);   // Sample one cycle after edge
      end
   end

   // Compare bus against data at each sample point
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !tx_on_o) begin
         buserr_r <= 1'b0;
      end else if (smp_r) begin
         buserr_r <= (rx_s != txd_s);
      end
   end

   // ************************************************************
   // Summary error and error pin
   // ************************************************************
   logic error_r, faults;
   assign faults = buserr_r || twarn_r || tshut_r || tmo_r || (|uv);

   // Summary tracks the seven faults
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         error_r <= 1'b0;
      end else begin
         error_r <= faults;
      end
   end

   // Error pin: summary in power modes, wake in low power
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         error_out_n_o <= 1'b1;
      end else if (np) begin
         error_out_n_o <= !faults;
      end else begin
         error_out_n_o <= !(wake_r || wake_set);
      end
   end
   assign mode_o = mode_r;

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   logic [`BTSF_ST_W-1:0] status;
   assign wb_req  = wb_cyc_i && wb_stb_i && !ack_r;
   assign wb_wr   = wb_req && wb_we_i;
   assign st_read = wb_req && !wb_we_i && (wb_adr_i == `BTSF_ADR_STATUS);
   assign status  = {error_r, uv, buserr_r, tmo_r, tshut_r, twarn_r,
                     pwron_r, wake_r, remote_r, local_r};
   assign wb_ack_o = ack_r;

   // Answer every request on the next edge
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_req;
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            `BTSF_ADR_CTRL, `BTSF_ADR_MODE: wb_dat_o <= {29'h0, mode_r};
            `BTSF_ADR_STATUS:               wb_dat_o <= {20'h0, status};
            default:                        wb_dat_o <= 32'h0;
         endcase
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   chk_tshut_blocks_tx: assert property (tshut_r |-> !tx_on_o) else $error("tx on in shutdown");
   chk_tmo_sets: assert property (normal && !tx_enable_n_n_s && (tx_cnt_r == `BTSF_CNT_W'(TX_ACTIVE_LIMIT))
      |=> tmo_r || tx_enable_n_n_s || !normal) else $error("timeout missed");
   chk_tmo_clears: assert property (tx_enable_n_n_s |=> !tmo_r) else $error("timeout kept");
   chk_buserr_off: assert property (!tx_on_o |=> !buserr_r) else $error("bus error kept");
   chk_wake_rise: assert property ($rose(local_r) || $rose(remote_r) |-> wake_r)
      else $error("wake not set");
   chk_uv_wake_clr: assert property ($rose(wake_r) |-> uv == 3'h0) else $error("uv kept");
   chk_err_summary: assert property (faults |=> error_r) else $error("summary missed");
   chk_err_clear: assert property (!faults && !$past(faults) |-> !error_r)
      else $error("summary stuck");
   chk_errpin_normal: assert property (normal && $past(normal) |-> error_out_n_o == !$past(faults))
      else $error("error pin wrong");
   chk_uv_sleep: assert property ((uv[0] || uv[2]) && !wake_set |=> mode_r == btsf_pkg::BTSF_SLEEP)
      else $error("no forced sleep");
   chk_pwron_clr: assert property (normal_entry |=> !pwron_r) else $error("power-on kept");
endmodule : btsf_flags
`default_nettype wire

// ---- btsf_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing figures of the flag block
// Assumes: 25 MHz system clock, 32-bit classic Wishbone register port
// Notes:   Definitions only
`ifndef BTSF_CONSTS_SVH
`define BTSF_CONSTS_SVH
// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define BTSF_ADR_CTRL       4'h0
`define BTSF_ADR_STATUS     4'h4
`define BTSF_ADR_MODE       4'h8
// ************************************************************
// Status field positions
// ************************************************************
`define BTSF_ST_LOCAL       0
`define BTSF_ST_REMOTE      1
`define BTSF_ST_WAKE        2
`define BTSF_ST_PWRON       3
`define BTSF_ST_TWARN       4
`define BTSF_ST_TSHUT       5
`define BTSF_ST_TMO         6
`define BTSF_ST_BUSERR      7
`define BTSF_ST_UV_LO       8
`define BTSF_ST_UV_HI       10
`define BTSF_ST_ERROR       11
`define BTSF_ST_W           12
// ************************************************************
// Reset values and timing
// ************************************************************
`define BTSF_MODE_RST       3'h2
// Synchroniser reset: enable, bus and wake pin rest high
`define BTSF_SYNC_RST       10'h00d
`define BTSF_CLK_NS         40
`define BTSF_TX_LIMIT_NS    1500000
`define BTSF_UV_DET_NS      10000
`define BTSF_UV_REC_NS      20000
`define BTSF_CNT_W          16
`endif

// ---- btsf_pkg.sv ----
// Purpose: Types shared by the flag block
// Assumes: Nothing beyond the constants header
// Notes:   Mode codes 5..7 are illegal
package btsf_pkg;
   // Operating modes of the transceiver
   typedef enum logic [2:0] {
      BTSF_NORMAL,
      BTSF_RX_ONLY,
      BTSF_STANDBY,
      BTSF_GOSLEEP,
      BTSF_SLEEP
   } btsf_mode_t;
endpackage : btsf_pkg

// ---- btsf_uv_if.sv ----
// Purpose: Link between the core and one supply filter
// Assumes: Single clock domain
// Notes:   One instance per supply
`timescale 1ns/1ns
`default_nettype none
interface btsf_uv_if;
   logic low;   // Supply below threshold
   logic clr;   // Forced clear pulse
   logic flag;  // Under-voltage flag
   modport filt (input low, input clr, output flag);
   modport core (output low, output clr, input flag);
endinterface : btsf_uv_if
`default_nettype wire

// ---- btsf_uv_filter.sv ----
// Purpose: Under-voltage flag with detection and recovery filters
// Assumes: low already synchronised
// Notes:   Forced clear beats everything and restarts the filter
`timescale 1ns/1ns
`default_nettype none
`include "btsf_consts.svh"
module btsf_uv_filter #(
   parameter logic [`BTSF_CNT_W-1:0] DET_CYC = 16'd250,  // Detection filter cycles
   parameter logic [`BTSF_CNT_W-1:0] REC_CYC = 16'd500   // Recovery filter cycles
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   btsf_uv_if.filt   uv
);
   logic [`BTSF_CNT_W-1:0] cnt_r;   // Cycles spent opposite to the flag
   logic                   flag_r;  // Flag state

   assign uv.flag = flag_r;

   // Count while the supply disagrees with the flag; flip when filter time is met
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || uv.clr || (uv.low == flag_r)) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // Flag follows the filtered supply state
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || uv.clr) begin
         flag_r <= 1'b0;
      end else if (uv.low && !flag_r && (cnt_r >= DET_CYC - 16'h0001)) begin
         flag_r <= 1'b1;
      end else if (!uv.low && flag_r && (cnt_r >= REC_CYC - 16'h0001)) begin
         flag_r <= 1'b0;
      end
   end
endmodule : btsf_uv_filter
`default_nettype wire

// ---- btsf_bus_model.sv ----
// Purpose: Far-side bus model that echoes the bit being sent
// Assumes: The transmitter enable gates the echo
// Notes:   The fault input inverts the echo to force a mismatch
`timescale 1ns/1ns
`default_nettype none
module btsf_bus_model (
   input  wire logic txd_i,     // Bit being sent
   input  wire logic tx_on_i,   // Transmitter enabled
   input  wire logic fault_i,   // Corrupt the echo
   output logic      bus_rx_o   // Level seen back on the bus
);
   // Idle bus reads high, so a released bus no longer follows the bit being sent
   assign bus_rx_o = tx_on_i ? (txd_i ^ fault_i) : 1'b1;
endmodule : btsf_bus_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the flag block
// Assumes: One-cycle ack, 2-flop input synchronisers
// Notes:   A short transmit limit keeps the run brief
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // **********************************************
   // Signals
   // **********************************************
   localparam int LIM = 200;  // Shortened enable limit
   logic        clk, rst, cyc, stb, we, ack, txon, error_out_n, rx, flt;
   logic        ten_n, txd, wpin, rwk, tw, tsd, bl, cl, il;
   logic [3:0]  adr, sel;
   logic [31:0] dw, dr;
   logic [2:0]  mode;
   logic [15:0] lfsr;          // Random source
   int          failures, n_checks, cycles;
   logic [31:0] expq[$];       // Expected read data

   btsf_flags #(.TX_ACTIVE_LIMIT(LIM)) DUT (
      .ref_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
      .wb_dat_o(dr), .wb_ack_o(ack), .tx_enable_n_i(ten_n), .txd_i(txd),
      .bus_rx_i(rx), .wake_pin_i(wpin), .remote_wake_i(rwk),
      .temp_warn_i(tw), .temp_shutdown_i(tsd), .bat_low_i(bl),
      .core_low_i(cl), .io_low_i(il), .tx_on_o(txon),
      .error_out_n_o(error_out_n), .mode_o(mode));
   btsf_bus_model PEER (.txd_i(txd), .tx_on_i(txon), .fault_i(flt), .bus_rx_o(rx));

   // Clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // **********************************************
   // Tasks
   // **********************************************
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   // One classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; dw <= d;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expq.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask : rd

   task automatic give_verdict();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Read results meet the oldest note
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         chk(dr, expq.pop_front());
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures++;
         give_verdict();
      end
   end

   // **********************************************
   // Sequence
   // **********************************************
   initial begin
      {cyc, stb, we, txd, rwk, tw, tsd, bl, cl, il, flt} = '0;
      adr = 4'h0; sel = 4'h0; dw = 32'h0; ten_n = 1'b1; wpin = 1'b1;
      lfsr = 16'h84ab; failures = 0; n_checks = 0; cycles = 0; rst = 1'b1;
      wt(8);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'(mode), 32'h2); chk(32'(error_out_n), 32'h1);
      rd(4'h4, 32'h008);
      rd(4'hc, 32'h0);
      wb(1'b1, 4'h0, 32'h0);
      rd(4'h8, 32'h0); rd(4'h4, 32'h0);
      // Random traffic echoed cleanly
      @(posedge clk); ten_n <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk); lfsr <= nxt(lfsr); txd <= lfsr[0];
         wt(4);
      end
      chk(32'(txon), 32'h1); rd(4'h4, 32'h0);
      @(posedge clk); flt <= 1'b1; txd <= ~txd;
      wt(6); rd(4'h4, 32'h880); chk(32'(error_out_n), 32'h0);
      @(posedge clk); flt <= 1'b0; txd <= ~txd;
      wt(6); rd(4'h4, 32'h0); chk(32'(error_out_n), 32'h1);
      @(posedge clk); flt <= 1'b1; txd <= ~txd;
      wt(6); rd(4'h4, 32'h880);
      @(posedge clk); ten_n <= 1'b1; flt <= 1'b0;
      wt(6); rd(4'h4, 32'h0);
      // Enable held past the limit
      @(posedge clk); ten_n <= 1'b0;
      wt(LIM - 10); chk(32'(txon), 32'h1);
      wt(20); chk(32'(txon), 32'h0); rd(4'h4, 32'h840);
      @(posedge clk); ten_n <= 1'b1;
      wt(6); rd(4'h4, 32'h0);
      // Thermal shutdown needs cool plus an enable fall
      @(posedge clk); tsd <= 1'b1;
      wt(6); @(posedge clk); ten_n <= 1'b0;
      wt(6); chk(32'(txon), 32'h0); rd(4'h4, 32'h820);
      @(posedge clk); tsd <= 1'b0;
      wt(6); rd(4'h4, 32'h820);
      @(posedge clk); ten_n <= 1'b1;
      wt(4); @(posedge clk); ten_n <= 1'b0;
      wt(6); rd(4'h4, 32'h0); chk(32'(txon), 32'h1);
      @(posedge clk); ten_n <= 1'b1;
      // Thermal warning, cleared by cooling then by a low-power read
      @(posedge clk); tw <= 1'b1;
      wt(6); rd(4'h4, 32'h810);
      @(posedge clk); tw <= 1'b0;
      wt(6); rd(4'h4, 32'h0);
      @(posedge clk); tw <= 1'b1;
      wt(6); wb(1'b1, 4'h0, 32'h2);
      rd(4'h4, 32'h810); rd(4'h4, 32'h0);
      @(posedge clk); tw <= 1'b0;
      // Local and remote wake in standby
      @(posedge clk); wpin <= 1'b0;
      wt(6); rd(4'h4, 32'h005); chk(32'(error_out_n), 32'h0);
      @(posedge clk); wpin <= 1'b1;
      wb(1'b1, 4'h0, 32'h0); rd(4'h4, 32'h001);
      wb(1'b1, 4'h0, 32'h2); rd(4'h4, 32'h0);
      @(posedge clk); rwk <= 1'b1;
      wt(6); @(posedge clk); rwk <= 1'b0;
      rd(4'h4, 32'h006);
      // Core supply filter edges
      @(posedge clk); cl <= 1'b1;
      wt(240); rd(4'h4, 32'h006);
      wt(25); rd(4'h4, 32'ha02); chk(32'(mode), 32'h2);
      @(posedge clk); cl <= 1'b0;
      wt(490); rd(4'h4, 32'ha02);
      wt(20); rd(4'h4, 32'h002);
      // Battery low forces sleep until a wake
      wb(1'b1, 4'h0, 32'h0);
      @(posedge clk); bl <= 1'b1;
      wt(265); chk(32'(mode), 32'h4); chk(32'(error_out_n), 32'h1);
      rd(4'h4, 32'h900); wb(1'b1, 4'h0, 32'h0); rd(4'h8, 32'h4);
      @(posedge clk); wpin <= 1'b0;
      wt(6); rd(4'h4, 32'h005);
      chk(32'(mode), 32'h2); chk(32'(error_out_n), 32'h0);
      @(posedge clk); wpin <= 1'b1; bl <= 1'b0;
      wt(4);
      if (expq.size() != 0) begin
         failures++;
      end
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
